/* File: rtl/dsl_device.sv */
// device end: status register pair, keyed locks and state sequencing
// How it works
// R01: 0xaa sets, 0x55 clears restart block latch
// R02: power-on reset keeps latch unless battery lost
// R03: regulator overvoltage forces restart block to one
// R04: restart from off needs wake edge, or wake level when restart unblocked
// R05: config lock resets one, set by key/exit/selftest
// R06: config lock cleared by 0xaa in diagnostic only
// R07: selftest control lock set by key, exits, selftest
// R08: selftest control lock cleared by 0xaa in diag/active/safe
// R09: control lock set by key, diag exit, selftest
// R10: control lock cleared by 0xaa in diag/active/safe
// R11: diag timeout hold set 0x55, cleared 0xaa
// R12: unheld diag timeout goes safe; held timer stays reset
// R13: safe timeout off resets one, keyed in diag only
// R14: safe timer expiry resets unless timeout switched off
// R15: mcu reset 0x5a enters reset and sets flag
// R16: reading status never clears mcu reset flag
// R17: status sync detect bit only with monitor on and clock good; sync_detect_valid follows switch_clock_source_sel
// R18: mcu error bit follows the error pin level
// R19: state field codes; reset state answers zeros
// R20: wake edge latch set on edge, cleared 0x8e/off
// R21: wrong key or wrong state leaves bits unchanged
`timescale 1ns/100ps
`default_nettype none
module dsl_device
#(
	parameter int DIAG_TO = dsl_pkg::DIAG_TO_CYCLES,
	parameter int SAFE_TIMER_SETTING = dsl_pkg::SAFE_TIMER_SETTING_CYCLES
)
(
	// clock and power-on reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// link
	dsl_link_if.dev   link,
	// supply and analog events
	input  wire logic battery_lost,
	input  wire logic internal_regulator_ov,
	input  wire logic logic_selftest_done,
	input  wire logic global_reset,
	input  wire logic shutdown_req,
	// pins
	input  wire logic wake_pin,
	input  wire logic mcu_err_pin,
	// clock monitor
	input  wire logic ext_clock_monitor,
	input  wire logic sync_clock_in_range,
	input  wire logic switch_clock_source_sel,
	// state and status
	output logic [2:0] device_state_field,
	output logic       auto_restart_block,
	output logic       sync_detect_valid
);
	import dsl_pkg::*;

	typedef enum logic [2:0] {st_off, st_reset, st_diag, st_active, st_safe} state_t;

	state_t     state;
	state_t     next_state;
	logic [2:0] wake_s;
	logic [2:0] err_s;
	logic       wake;
	logic       wake_d;
	logic       mcu_err;
	logic       wake_edge;
	logic       cfg_lock;
	logic       bist_lock;
	logic       ctrl_lock;
	logic       diag_hold;
	logic       safe_off;
	logic       mcu_rst_flag;
	logic       por_first;
	logic [15:0] timer;
	logic       live;
	logic       in_run;
	logic [7:0] stat_one;
	logic [7:0] stat_two;

	function automatic logic hit(input cmd_t c, input logic [7:0] k);
		// only the first edge of a request acts, not the ack edge
		hit = link.req && !link.ack && link.cmd == c && link.data == k;
	endfunction

	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wake_s  <= 3'h0;
			err_s   <= 3'h0;
			wake    <= 1'b0;
			mcu_err <= 1'b0;
			wake_d  <= 1'b0;
		end
		else
		begin
			wake_s <= {wake_s[1:0], wake_pin};
			err_s  <= {err_s[1:0], mcu_err_pin};
			if (wake_s[1] == wake_s[2])
				wake <= wake_s[2];
			if (err_s[1] == err_s[2])
				mcu_err <= err_s[2]; // [R18]
			wake_d <= wake;
		end
	end

	assign in_run = state == st_diag || state == st_active || state == st_safe;
	assign live   = link.req && in_run;

	//------------------------------------------------------------
	// state sequencing
	//------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			st_off:
				if (auto_restart_block ? wake_edge : (wake || wake_edge)) // [R04]
					next_state = st_reset;
			st_reset:
				if (timer == 16'(RESET_HOLD_CYCLES - 1))
					next_state = st_diag;
			st_diag:
				if (hit(cmd_go_active, KEY_55))
					next_state = st_active;
				else if (!diag_hold && timer == 16'(DIAG_TO - 1)) // [R12]
					next_state = st_safe;
			st_active:
				next_state = st_active;
			st_safe:
				if (hit(cmd_safe_exit, KEY_55))
					next_state = st_diag; // [R14]
				else if (!safe_off && timer == 16'(SAFE_TIMER_SETTING - 1)) // [R14]
					next_state = st_reset;
		endcase
		if (in_run && hit(cmd_mcu_reset, KEY_RST)) // [R15]
			next_state = st_reset;
		if (in_run && global_reset)
			next_state = st_reset;
		if (shutdown_req)
			next_state = st_off;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= st_reset;
		else
			state <= next_state;
	end

	// timer restarts on every state change; held in diag while masked
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer <= 16'h0;
		else if (next_state != state || (state == st_diag && diag_hold)) // [R12]
			timer <= 16'h0;
		else if (state != st_off && state != st_active)
			timer <= timer + 16'h1;
	end

	//------------------------------------------------------------
	// restart block latch, kept across power-on reset
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			por_first <= 1'b1;
		else
			por_first <= 1'b0;
	end

	always_ff @(posedge hclk)
	begin
		if (internal_regulator_ov)
			auto_restart_block <= 1'b1; // [R03]
		else if (por_first && battery_lost)
			auto_restart_block <= 1'b0; // [R02]
		else if (live && hit(cmd_block_autorestart, KEY_AA))
			auto_restart_block <= 1'b1; // [R01]
		else if (live && hit(cmd_allow_autorestart, KEY_55))
			auto_restart_block <= 1'b0; // [R01] [R21]
	end

	//------------------------------------------------------------
	// write-protect locks; set wins over clear
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_lock  <= RST_CFG_LOCK;
			bist_lock <= RST_BIST_LOCK;
			ctrl_lock <= RST_CTRL_LOCK;
		end
		else
		begin
			if ((state == st_diag && hit(cmd_protect_config, KEY_55))
				|| (state == st_diag && next_state != st_diag) || logic_selftest_done)
				cfg_lock <= 1'b1; // [R05]
			else if (state == st_diag && hit(cmd_unprotect_config, KEY_AA))
				cfg_lock <= 1'b0; // [R06] [R21]
			if ((live && hit(cmd_protect_control, KEY_55))
				|| (in_run && next_state != state) || logic_selftest_done)
				bist_lock <= 1'b1; // [R07]
			else if (live && hit(cmd_unprotect_control, KEY_AA))
				bist_lock <= 1'b0; // [R08]
			if ((live && hit(cmd_protect_control, KEY_55))
				|| (state == st_diag && next_state != st_diag) || logic_selftest_done)
				ctrl_lock <= 1'b1; // [R09]
			else if (live && hit(cmd_unprotect_control, KEY_AA))
				ctrl_lock <= 1'b0; // [R10]
		end
	end

	//------------------------------------------------------------
	// timeout controls, reset cause, wake edge
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			diag_hold <= RST_DIAG_HOLD;
			safe_off  <= RST_SAFE_OFF;
		end
		else
		begin
			if (live && hit(cmd_hold_diag_timeout, KEY_55))
				diag_hold <= 1'b1; // [R11]
			else if (live && hit(cmd_release_diag_timeout, KEY_AA))
				diag_hold <= 1'b0; // [R11]
			if (state == st_diag && hit(cmd_safe_timeout_off, KEY_55))
				safe_off <= 1'b1; // [R13]
			else if (state == st_diag && hit(cmd_safe_timeout_on, KEY_AA))
				safe_off <= 1'b0; // [R13]
		end
	end

	// flag changes only on entry to reset, never on a read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mcu_rst_flag <= 1'b0;
		else if (state != st_reset && next_state == st_reset)
			mcu_rst_flag <= in_run && hit(cmd_mcu_reset, KEY_RST); // [R15] [R16]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wake_edge <= 1'b0;
		else if (wake && !wake_d)
			wake_edge <= 1'b1; // [R20]
		else if (state != st_off && next_state == st_off)
			wake_edge <= 1'b0; // [R20]
		else if (live && hit(cmd_clear_wake_edge, KEY_WAKE))
			wake_edge <= 1'b0; // [R20]
	end

	//------------------------------------------------------------
	// status and link answer
	//------------------------------------------------------------
	always_comb
	begin
		unique case (state)
			st_diag:   device_state_field = FIELD_DIAG; // [R19]
			st_active: device_state_field = FIELD_ACTIVE;
			st_safe:   device_state_field = FIELD_SAFE;
			default:   device_state_field = FIELD_NONE;
		endcase
	end

	assign sync_detect_valid = switch_clock_source_sel;
	assign stat_one = {device_state_field, 1'b0, auto_restart_block, cfg_lock, bist_lock,
		ctrl_lock};
	assign stat_two = {1'b0, diag_hold, safe_off, mcu_rst_flag,
		ext_clock_monitor && sync_clock_in_range, mcu_err, wake_edge, wake}; // [R17] [R18]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			link.ack   <= 1'b0;
			link.rdata <= 8'h0;
		end
		else
		begin
			link.ack   <= link.req && !link.ack;
			link.rdata <= 8'h0;
			if (in_run && link.req && link.cmd == cmd_read_status_one)
				link.rdata <= stat_one;
			else if (in_run && link.req && link.cmd == cmd_read_status_two)
				link.rdata <= stat_two; // [R16] [R19]
		end
	end
endmodule
`default_nettype wire

/* File: inc/dsl_pkg.sv */
// constants and types shared by both ends of the status and lock link
package dsl_pkg;
	//------------------------------------------------------------
	// command keys
	//------------------------------------------------------------
	localparam logic [7:0] KEY_55    = 8'h55;
	localparam logic [7:0] KEY_AA    = 8'haa;
	localparam logic [7:0] KEY_RST   = 8'h5a;
	localparam logic [7:0] KEY_WAKE  = 8'h8e;
	//------------------------------------------------------------
	// link commands
	//------------------------------------------------------------
	typedef enum logic [4:0]
	{
		cmd_block_autorestart,
		cmd_allow_autorestart,
		cmd_protect_config,
		cmd_unprotect_config,
		cmd_protect_control,
		cmd_unprotect_control,
		cmd_hold_diag_timeout,
		cmd_release_diag_timeout,
		cmd_safe_timeout_off,
		cmd_safe_timeout_on,
		cmd_mcu_reset,
		cmd_clear_wake_edge,
		cmd_safe_exit,
		cmd_go_active,
		cmd_read_status_one,
		cmd_read_status_two
	} cmd_t;
	//------------------------------------------------------------
	// device state field codes
	//------------------------------------------------------------
	localparam logic [2:0] FIELD_NONE   = 3'h0;
	localparam logic [2:0] FIELD_DIAG   = 3'h1;
	localparam logic [2:0] FIELD_ACTIVE = 3'h2;
	localparam logic [2:0] FIELD_SAFE   = 3'h4;
	//------------------------------------------------------------
	// reset values
	//------------------------------------------------------------
	localparam logic RST_CFG_LOCK  = 1'b1;
	localparam logic RST_BIST_LOCK = 1'b1;
	localparam logic RST_CTRL_LOCK = 1'b1;
	localparam logic RST_DIAG_HOLD = 1'b0;
	localparam logic RST_SAFE_OFF  = 1'b1;
	//------------------------------------------------------------
	// timing (cycles at 10 MHz)
	//------------------------------------------------------------
	localparam int RESET_HOLD_CYCLES = 4;
	localparam int DIAG_TO_CYCLES    = 4000;
	localparam int SAFE_TIMER_SETTING_CYCLES    = 4000;
	//------------------------------------------------------------
	// controller register map (byte addresses)
	//------------------------------------------------------------
	localparam logic [3:0] OFS_COMMAND = 4'h0;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam int         CMD_DATA_LSB = 0;
	localparam int         CMD_CODE_LSB = 8;
	localparam int         STS_BUSY_BIT = 8;
endpackage

/* File: inc/dsl_link_if.sv */
// command link between the controller and the device
`timescale 1ns/100ps
`default_nettype none
interface dsl_link_if;
	import dsl_pkg::*;
	logic       req;
	cmd_t       cmd;
	logic [7:0] data;
	logic       ack;
	logic [7:0] rdata;
	modport dev (input req, input cmd, input data, output ack, output rdata);
	modport ctl (output req, output cmd, output data, input ack, input rdata);
endinterface
`default_nettype wire

/* File: rtl/dsl_controller.sv */
// controller end: AHB-Lite command and status registers driving the link
`timescale 1ns/100ps
`default_nettype none
module dsl_controller
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// link
	dsl_link_if.ctl          link
);
	import dsl_pkg::*;

	logic       wr_pend;
	logic [3:0] addr_q;
	logic       busy;
	logic [7:0] last_rdata;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	//------------------------------------------------------------
	// address phase capture
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			addr_q  <= 4'h0;
		end
		else if (hready)
		begin
			wr_pend <= hsel && htrans[1] && hwrite && hsize == 3'h2;
			addr_q  <= haddr[3:0];
		end
	end

	//------------------------------------------------------------
	// command issue; a write while busy is dropped
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			busy      <= 1'b0;
			link.req  <= 1'b0;
			link.cmd  <= cmd_read_status_one;
			link.data <= 8'h0;
		end
		else if (busy)
		begin
			if (link.ack)
			begin
				busy     <= 1'b0;
				link.req <= 1'b0;
			end
		end
		else if (wr_pend && addr_q == OFS_COMMAND)
		begin
			busy      <= 1'b1;
			link.req  <= 1'b1;
			link.cmd  <= cmd_t'(hwdata[CMD_CODE_LSB +: 5]);
			link.data <= hwdata[CMD_DATA_LSB +: 8];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			last_rdata <= 8'h0;
		else if (busy && link.ack)
			last_rdata <= link.rdata;
	end

	//------------------------------------------------------------
	// read data
	//------------------------------------------------------------
	always_comb
	begin
		hrdata = 32'h0;
		if (addr_q == OFS_STATUS)
			hrdata = {23'h0, busy, last_rdata};
	end
endmodule
`default_nettype wire

/* File: tb/dsl_monitor.sv */
// link checker: handshake and status answer properties
`timescale 1ns/100ps
`default_nettype none
module dsl_monitor
(
	// clock and reset
	input wire logic          hclk,
	input wire logic          hresetn,
	// link signals
	input wire logic          req,
	input wire dsl_pkg::cmd_t cmd,
	input wire logic [7:0]    data,
	input wire logic          ack,
	input wire logic [7:0]    rdata,
	// device state field
	input wire logic [2:0]    state_field
);
	import dsl_pkg::*;
	logic flag_v;
	logic flag_q;
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	//------------------------------------------------------------
	// flag memory, kept while only status reads pass
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_v <= 1'h0;
		else if (state_field == FIELD_NONE)
			flag_v <= 1'h0;
		else if (ack)
			flag_v <= (cmd == cmd_read_status_two) || (flag_v && cmd == cmd_read_status_one);
	end
	always_ff @(posedge hclk)
	begin
		if (ack && cmd == cmd_read_status_two)
			flag_q <= rdata[4];
	end
	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	ack_given_a: assert property (req && !ack |=> ack)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack |-> req && $past(req))
		else $error("ack without a held request");
	req_hold_a: assert property (req && !ack |=> $stable(cmd) && $stable(data))
		else $error("command changed before ack");
	req_release_a: assert property (req && ack |=> !req)
		else $error("request kept after ack");
	state_code_a: assert property (ack && cmd == cmd_read_status_one
		|-> $onehot0(rdata[7:5]) && !rdata[4])
		else $error("bad state code in status one");
	status_resv_a: assert property (ack && cmd == cmd_read_status_two |-> !rdata[7])
		else $error("reserved bit set in status two");
	flag_keep_a: assert property (ack && cmd == cmd_read_status_two && flag_v
		|-> rdata[4] == flag_q)
		else $error("reset flag changed by reading");
	cover property (ack && cmd == cmd_mcu_reset && data == KEY_RST);
	cover property (ack && cmd == cmd_read_status_one && rdata[7:5] == FIELD_SAFE);
	cover property (ack && cmd == cmd_unprotect_control && data == KEY_AA);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// testbench: both ends joined, driven over AHB-Lite
`timescale 1ns/100ps
`default_nettype none
module tb;
	import dsl_pkg::*;
	localparam int TO = 300;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic        battery_lost;
	logic        regulator_ov;
	logic        wake_pin;
	logic        mcu_err_pin;
	logic        clk_mon;
	logic        clk_good;
	logic        clk_sel;
	logic        selftest_done;
	logic        greset;
	logic        shutdown;
	logic [2:0]  state_field;
	logic        restart_block;
	logic        sync_valid;
	int          err_count;
	int          n_checks;
	int          i;
	//------------------------------------------------------------
	// both ends and the checker
	//------------------------------------------------------------
	dsl_link_if dsl_link_if_inst ();
	dsl_controller dsl_controller_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.link(dsl_link_if_inst.ctl));
	dsl_device #(.DIAG_TO(TO), .SAFE_TIMER_SETTING(TO)) dsl_device_inst (.hclk(hclk),
		.hresetn(hresetn), .link(dsl_link_if_inst.dev), .battery_lost(battery_lost),
		.internal_regulator_ov(regulator_ov), .logic_selftest_done(selftest_done),
		.global_reset(greset), .shutdown_req(shutdown), .wake_pin(wake_pin),
		.mcu_err_pin(mcu_err_pin), .ext_clock_monitor(clk_mon),
		.sync_clock_in_range(clk_good), .switch_clock_source_sel(clk_sel),
		.device_state_field(state_field), .auto_restart_block(restart_block),
		.sync_detect_valid(sync_valid));
	dsl_monitor dsl_monitor_inst (.hclk(hclk), .hresetn(hresetn),
		.req(dsl_link_if_inst.req), .cmd(dsl_link_if_inst.cmd), .data(dsl_link_if_inst.data),
		.ack(dsl_link_if_inst.ack), .rdata(dsl_link_if_inst.rdata),
		.state_field(state_field));
	always #50 hclk = ~hclk;
	//------------------------------------------------------------
	// tasks
	//------------------------------------------------------------
	task automatic tally_and_finish;
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic fail_out;
		err_count++;
		tally_and_finish();
	endtask
	// sample before the edge, act after it
	task automatic ready_wait(output logic [31:0] rd);
		int   n;
		logic ok;
		n = 0;
		do
		begin
			@(negedge hclk);
			ok = hready;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end
		while (ok !== 1'h1 && n < 50);
		if (ok !== 1'h1)
			fail_out();
	endtask
	task automatic ahb(input logic wr, input logic [3:0] ofs, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [31:0] dummy;
		hsel <= 1'h1;
		haddr <= {28'h0, ofs};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		ready_wait(dummy);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		ready_wait(rd);
	endtask
	task automatic issue(input cmd_t c, input logic [7:0] k);
		logic [31:0] rd;
		int          n;
		ahb(1'h1, OFS_COMMAND, (32'(c) << CMD_CODE_LSB) | (32'(k) << CMD_DATA_LSB), rd);
		n = 0;
		do
		begin
			ahb(1'h0, OFS_STATUS, 32'h0, rd);
			n++;
		end
		while (rd[STS_BUSY_BIT] !== 1'h0 && n < 20);
		if (rd[STS_BUSY_BIT] !== 1'h0)
			fail_out();
	endtask
	task automatic peek(input logic two, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] rd;
		issue(two ? cmd_read_status_two : cmd_read_status_one, 8'h00);
		ahb(1'h0, OFS_STATUS, 32'h0, rd);
		check({24'h0, rd[7:0] & m}, {24'h0, e});
	endtask
	task automatic step(input cmd_t c, input logic [7:0] k, input logic two,
		input logic [7:0] m, input logic [7:0] e);
		issue(c, k);
		peek(two, m, e);
	endtask
	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial
	begin
		hclk = 1'h0;
		hresetn = 1'h0;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{regulator_ov, wake_pin, mcu_err_pin, selftest_done, greset, shutdown} = '0;
		{battery_lost, clk_mon, clk_good, clk_sel} = 4'hf;
		err_count = 0;
		n_checks = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		repeat (8) @(posedge hclk);
		battery_lost <= 1'h0;
		step(cmd_hold_diag_timeout, KEY_55, 1'h1, 8'hff, 8'h68);
		peek(1'h0, 8'hff, 8'h27);
		for (i = 0; i < 4; i++)
		begin
			clk_mon <= i[0];
			clk_good <= i[1];
			clk_sel <= i[0];
			mcu_err_pin <= i[1];
			repeat (4) @(posedge hclk);
			check({31'h0, sync_valid}, {31'h0, i[0]});
			peek(1'h1, 8'h0c, {4'h0, i[0] & i[1], i[1], 2'h0});
		end
		step(cmd_block_autorestart, KEY_AA, 1'h0, 8'h08, 8'h08);
		step(cmd_allow_autorestart, KEY_AA, 1'h0, 8'h08, 8'h08);
		step(cmd_allow_autorestart, KEY_55, 1'h0, 8'h08, 8'h00);
		step(cmd_unprotect_config, KEY_55, 1'h0, 8'h04, 8'h04);
		step(cmd_unprotect_config, KEY_AA, 1'h0, 8'h04, 8'h00);
		step(cmd_protect_config, KEY_55, 1'h0, 8'h04, 8'h04);
		step(cmd_unprotect_config, KEY_AA, 1'h0, 8'h04, 8'h00);
		step(cmd_safe_timeout_on, KEY_AA, 1'h1, 8'h20, 8'h00);
		step(cmd_safe_timeout_off, KEY_55, 1'h1, 8'h20, 8'h20);
		step(cmd_safe_timeout_on, KEY_AA, 1'h1, 8'h20, 8'h00);
		step(cmd_unprotect_control, KEY_AA, 1'h0, 8'h03, 8'h00);
		step(cmd_go_active, KEY_55, 1'h0, 8'hff, 8'h47);
		step(cmd_unprotect_config, KEY_AA, 1'h0, 8'h04, 8'h04);
		step(cmd_safe_timeout_off, KEY_55, 1'h1, 8'h20, 8'h00);
		step(cmd_unprotect_control, KEY_AA, 1'h0, 8'h03, 8'h00);
		step(cmd_protect_control, KEY_55, 1'h0, 8'h03, 8'h03);
		regulator_ov <= 1'h1;
		@(posedge hclk);
		regulator_ov <= 1'h0;
		peek(1'h0, 8'h08, 8'h08);
		check({31'h0, restart_block}, 32'h1);
		wake_pin <= 1'h1;
		repeat (8) @(posedge hclk);
		peek(1'h1, 8'h03, 8'h03);
		step(cmd_clear_wake_edge, KEY_WAKE, 1'h1, 8'h03, 8'h01);
		wake_pin <= 1'h0;
		issue(cmd_mcu_reset, KEY_RST);
		repeat (8) @(posedge hclk);
		peek(1'h1, 8'h10, 8'h10);
		peek(1'h1, 8'h10, 8'h10);
		peek(1'h0, 8'he0, 8'h20);
		step(cmd_hold_diag_timeout, KEY_55, 1'h1, 8'h40, 8'h40);
		repeat (TO + 100) @(posedge hclk);
		peek(1'h0, 8'he0, 8'h20);
		step(cmd_release_diag_timeout, KEY_AA, 1'h1, 8'h40, 8'h00);
		repeat (TO + 100) @(posedge hclk);
		peek(1'h0, 8'he0, 8'h80);
		step(cmd_safe_exit, KEY_55, 1'h0, 8'he0, 8'h20);
		step(cmd_safe_timeout_on, KEY_AA, 1'h1, 8'h20, 8'h00);
		repeat (2 * TO + 100) @(posedge hclk);
		peek(1'h0, 8'he0, 8'h20);
		peek(1'h1, 8'h10, 8'h00);
		issue(cmd_unprotect_config, KEY_AA);
		step(cmd_unprotect_control, KEY_AA, 1'h0, 8'h07, 8'h00);
		selftest_done <= 1'h1;
		@(posedge hclk);
		selftest_done <= 1'h0;
		peek(1'h0, 8'h07, 8'h07);
		greset <= 1'h1;
		@(posedge hclk);
		greset <= 1'h0;
		@(negedge hclk);
		check({29'h0, state_field}, {29'h0, FIELD_NONE});
		repeat (8) @(posedge hclk);
		wake_pin <= 1'h1;
		repeat (8) @(posedge hclk);
		shutdown <= 1'h1;
		@(posedge hclk);
		shutdown <= 1'h0;
		repeat (20) @(posedge hclk);
		check({29'h0, state_field}, {29'h0, FIELD_NONE});
		wake_pin <= 1'h0;
		repeat (8) @(posedge hclk);
		wake_pin <= 1'h1;
		repeat (20) @(posedge hclk);
		check({29'h0, state_field}, {29'h0, FIELD_DIAG});
		step(cmd_allow_autorestart, KEY_55, 1'h0, 8'h08, 8'h00);
		shutdown <= 1'h1;
		@(posedge hclk);
		shutdown <= 1'h0;
		@(negedge hclk);
		check({29'h0, state_field}, {29'h0, FIELD_NONE});
		repeat (20) @(posedge hclk);
		check({29'h0, state_field}, {29'h0, FIELD_DIAG});
		tally_and_finish();
	end
endmodule
`default_nettype wire
